// *** src/stf_status_regs.sv ***
`timescale 1ns/1ns
`include "stf_defs.svh"

module stf_status_regs
    import stf_pkg::*;
#(
    parameter int SHORT_CYCLES = `STF_SHORT_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic powerOnReset,
    input wire logic softReset,
    input wire stf_events_t eventsIn,
    input wire stf_qual_t qualIn,
    input wire stf_cmd_t cmdIn,
    output logic [7:0] readData,
    output logic readValid,
    output logic addrHit,
    output logic failSafeRequest,
    output logic moduleDisable,
    output logic severeLongWait
);
    // ------------------------------------------------------------
    // input synchronisers (events come from analog comparators)
    // ------------------------------------------------------------
    stf_events_t evMeta_r;
    stf_events_t evSync_r;
    stf_qual_t qMeta_r;
    stf_qual_t qSync_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            evMeta_r <= '0;
            evSync_r <= '0;
            qMeta_r <= '0;
            qSync_r <= '0;
        end else begin
            evMeta_r <= eventsIn;
            evSync_r <= evMeta_r;
            qMeta_r <= qualIn;
            qSync_r <= qMeta_r;
        end
    end

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    function automatic logic [1:0] decodeAddr(input logic [6:0] addr);
        case (addr)
            `STF_ADDR_SUPA: decodeAddr = 2'd1;
            `STF_ADDR_SUPB: decodeAddr = 2'd2;
            `STF_ADDR_THRM: decodeAddr = 2'd3;
            default: decodeAddr = 2'd0;
        endcase
    endfunction

    logic [6:0] cmdAddr;
    logic cmdClear;
    logic [1:0] cmdSel;
    logic clrSupA;
    logic clrSupB;
    logic clrThrm;

    assign cmdAddr = cmdIn.frame[`STF_CMD_ADDR_HI:`STF_CMD_ADDR_LO];
    assign cmdClear = cmdIn.frame[`STF_CMD_MODE_BIT];
    assign cmdSel = decodeAddr(cmdAddr);
    assign clrSupA = cmdIn.valid && cmdClear && (cmdSel == 2'd1);
    assign clrSupB = cmdIn.valid && cmdClear && (cmdSel == 2'd2);
    assign clrThrm = cmdIn.valid && cmdClear && (cmdSel == 2'd3);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    logic shortDetect;
    logic safePulse;

    stf_short_timer #(
        .SHORT_CYCLES(SHORT_CYCLES)
    ) uShort (
        .clk(clk),
        .rst(rst),
        .mainRailOn(qSync_r.mainRailOn),
        .mainUnder(evSync_r.mainUnder),
        .shortDetect(shortDetect)
    );

    stf_severe_counter uSevere (
        .clk(clk),
        .rst(rst),
        .severeEvent(evSync_r.severeTsd),
        .severeQuiet(!evSync_r.severeTsd), // a quiet cycle breaks the run
        .safeState(safePulse),
        .longWait(severeLongWait)
    );

    // ------------------------------------------------------------
    // set conditions
    // ------------------------------------------------------------
    logic [7:0] setSupA;
    logic [7:0] setSupB;
    logic [7:0] setThrm;
    logic inStop;
    logic sleepRailOff;
    logic stopExcept;
    logic underAllowed;
    logic [7:0] supA_r;
    logic [7:0] supA_nxt;
    logic [7:0] supB_r;
    logic [7:0] supB_nxt;
    logic [7:0] thrm_r;
    logic [7:0] thrm_nxt;

    assign inStop = (qSync_r.mode == STF_MODE_STOP);
    assign sleepRailOff = (qSync_r.mode == STF_MODE_SLEEP) && !qSync_r.mainRailOn;
    assign stopExcept = qSync_r.loadAbovePeak || supA_r[`STF_BIT_MAIN_PREWARN];

    always_comb begin
        case (qSync_r.mode)
            STF_MODE_RESTART: underAllowed = 1'b0;
            STF_MODE_INIT: underAllowed = qSync_r.resetOutputReleased;
            STF_MODE_NORMAL,
            STF_MODE_STOP: underAllowed = 1'b1;
            default: underAllowed = 1'b0;
        endcase
        if (shortDetect) begin
            underAllowed = 1'b1;
        end
        if (sleepRailOff) begin
            underAllowed = 1'b0;
        end
    end

    always_comb begin
        setSupA = '0;
        setSupA[`STF_BIT_BAT_LOW] = evSync_r.batteryLow && qSync_r.mainRailOn
            && (!inStop || stopExcept);
        setSupA[`STF_BIT_BAT_HIGH] = evSync_r.batteryHigh && qSync_r.mainRailOn
            && (qSync_r.pumpEnableBit || !inStop || stopExcept);
        setSupA[`STF_BIT_MAIN_OVER] = evSync_r.mainOver && !sleepRailOff;
        setSupA[`STF_BIT_MAIN_PREWARN] = evSync_r.mainPrewarn;
        setSupB = '0;
        setSupB[`STF_BIT_AUX_OT] = evSync_r.auxOvertemp;
        setSupB[`STF_BIT_AUX_UNDER] = evSync_r.auxUnder;
        setSupB[`STF_BIT_MAIN_SHORT] = shortDetect && !sleepRailOff;
        setSupB[`STF_BIT_MAIN_UNDER] = evSync_r.mainUnder && underAllowed;
        setThrm = '0;
        setThrm[`STF_BIT_SEVERE_SAFE] = safePulse;
        setThrm[`STF_BIT_SEVERE_TSD] = evSync_r.severeTsd;
        setThrm[`STF_BIT_MODULE_TSD] = evSync_r.moduleTsd;
        setThrm[`STF_BIT_THERM_PREWARN] = evSync_r.thermPrewarn;
    end

    // ------------------------------------------------------------
    // sticky registers
    // ------------------------------------------------------------
    // set is or-ed after the clear so a same-cycle event survives
    function automatic logic [7:0] stickyNext(
        input logic [7:0] cur,
        input logic [7:0] set,
        input logic clr,
        input logic [7:0] mask
    );
        logic [7:0] held;
        held = clr ? `STF_BYTE_ZERO : cur;
        stickyNext = (held | set) & mask;
    endfunction

    always_comb begin
        supA_nxt = stickyNext(supA_r, setSupA, clrSupA, `STF_MASK_SUPA);
        supB_nxt = stickyNext(supB_r, setSupB, clrSupB, `STF_MASK_SUPB);
        thrm_nxt = stickyNext(thrm_r, setThrm, clrThrm, `STF_MASK_THRM);
        if (softReset) begin
            supA_nxt = `STF_RST_SUPA;
            supB_nxt = `STF_RST_SUPB_SOFT;
            thrm_nxt = `STF_RST_THRM;
        end
    end

    // rst is the power-on reset path; powerOnReset taken as alias
    always_ff @(posedge clk) begin
        if (rst || powerOnReset) begin
            supA_r <= `STF_RST_SUPA;
            supB_r <= `STF_RST_SUPB_POR;
            thrm_r <= `STF_RST_THRM;
        end else begin
            supA_r <= supA_nxt;
            supB_r <= supB_nxt;
            thrm_r <= thrm_nxt;
        end
    end

    // ------------------------------------------------------------
    // read answer: content before any clear of the same command
    // ------------------------------------------------------------
    logic [7:0] readData_r;
    logic [7:0] readData_nxt;
    logic readValid_r;

    always_comb begin
        case (cmdSel)
            2'd1: readData_nxt = supA_r;
            2'd2: readData_nxt = supB_r;
            2'd3: readData_nxt = thrm_r;
            default: readData_nxt = `STF_BYTE_ZERO;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            readData_r <= `STF_BYTE_ZERO;
            readValid_r <= 1'b0;
        end else begin
            readData_r <= cmdIn.valid ? readData_nxt : readData_r;
            readValid_r <= cmdIn.valid;
        end
    end

    assign readData = readData_r;
    assign readValid = readValid_r;
    assign addrHit = cmdIn.valid && (cmdSel != 2'd0);
    assign failSafeRequest = evSync_r.severeTsd;
    assign moduleDisable = evSync_r.moduleTsd;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence clrSupBSeq;
        clrSupB && !setSupB[`STF_BIT_MAIN_UNDER] && !softReset && !powerOnReset;
    endsequence

    // eight cycles with no safe-state set; used twice to keep repetition small
    sequence noSafeSeq;
        (!setThrm[`STF_BIT_SEVERE_SAFE]) [*8];
    endsequence

    a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
        ((supA_r & ~`STF_MASK_SUPA) == 0) && ((supB_r & ~`STF_MASK_SUPB) == 0)
        && ((thrm_r & ~`STF_MASK_THRM) == 0))
        else $error("reserved bit set");
    a_event_wins: assert property (@(posedge clk) disable iff (rst)
        (clrThrm && setThrm[`STF_BIT_THERM_PREWARN] && !softReset && !powerOnReset)
        |=> thrm_r[`STF_BIT_THERM_PREWARN])
        else $error("event lost to clear");
    a_thermal_sticky: assert property (@(posedge clk) disable iff (rst)
        (thrm_r[`STF_BIT_MODULE_TSD] && !clrThrm && !softReset && !powerOnReset)
        |=> thrm_r[`STF_BIT_MODULE_TSD])
        else $error("thermal flag dropped");
    a_restart_under: assert property (@(posedge clk) disable iff (rst)
        (qSync_r.mode == STF_MODE_RESTART && !shortDetect) |-> !setSupB[`STF_BIT_MAIN_UNDER])
        else $error("under set in restart");
    a_clear_under: assert property (@(posedge clk) disable iff (rst)
        clrSupBSeq |=> !supB_r[`STF_BIT_MAIN_UNDER])
        else $error("clear failed");
    a_sleep_short: assert property (@(posedge clk) disable iff (rst)
        sleepRailOff |-> (setSupB[`STF_BIT_MAIN_SHORT] == 1'b0))
        else $error("short set while rail off");
    a_stop_bat_low: assert property (@(posedge clk) disable iff (rst)
        (inStop && !stopExcept) |-> !setSupA[`STF_BIT_BAT_LOW])
        else $error("battery low in stop");
    a_pump_bat_high: assert property (@(posedge clk) disable iff (rst)
        (evSync_r.batteryHigh && qSync_r.mainRailOn && qSync_r.pumpEnableBit
         && !clrSupA && !softReset && !powerOnReset) |=> supA_r[`STF_BIT_BAT_HIGH])
        else $error("battery high missed");
    a_read_answer: assert property (@(posedge clk) disable iff (rst)
        (cmdIn.valid && cmdSel == 2'd3) |=> (readValid && readData == $past(thrm_r)))
        else $error("read answer wrong");
    a_soft_clear: assert property (@(posedge clk) disable iff (rst)
        (softReset && !powerOnReset) |=> (supA_r == `STF_RST_SUPA
            && supB_r == `STF_RST_SUPB_SOFT && thrm_r == `STF_RST_THRM))
        else $error("soft reset missed");
    a_power_marker: assert property (@(posedge clk) disable iff (rst)
        powerOnReset |=> (supB_r == `STF_RST_SUPB_POR))
        else $error("power-on marker missing");
    a_unmapped_zero: assert property (@(posedge clk) disable iff (rst)
        (cmdIn.valid && cmdSel == 2'd0) |=> (readValid && readData == `STF_BYTE_ZERO))
        else $error("unmapped read not zero");
    a_safe_run: assert property (@(posedge clk) disable iff (rst)
        !evSync_r.severeTsd |=> noSafeSeq ##1 noSafeSeq)
        else $error("safe flag before long run");

endmodule // stf_status_regs

// *** inc/stf_defs.svh ***
`ifndef STF_DEFS_SVH
`define STF_DEFS_SVH

// register addresses on the 7-bit serial address field
`define STF_ADDR_SUPA 7'h40
`define STF_ADDR_SUPB 7'h41
`define STF_ADDR_THRM 7'h42

// serial command layout
`define STF_CMD_W 16
`define STF_CMD_MODE_BIT 7
`define STF_CMD_ADDR_HI 6
`define STF_CMD_ADDR_LO 0
`define STF_CMD_DATA_HI 15
`define STF_CMD_DATA_LO 8

// writable (clearable) masks; reserved bits are outside them
`define STF_MASK_SUPA 8'h63
`define STF_MASK_SUPB 8'h9D
`define STF_MASK_THRM 8'h0F

// field positions, register a
`define STF_BIT_BAT_LOW 6
`define STF_BIT_BAT_HIGH 5
`define STF_BIT_MAIN_OVER 1
`define STF_BIT_MAIN_PREWARN 0
// field positions, register b
`define STF_BIT_POWER_ON 7
`define STF_BIT_AUX_OT 4
`define STF_BIT_AUX_UNDER 3
`define STF_BIT_MAIN_SHORT 2
`define STF_BIT_MAIN_UNDER 0
// field positions, thermal register
`define STF_BIT_SEVERE_SAFE 3
`define STF_BIT_SEVERE_TSD 2
`define STF_BIT_MODULE_TSD 1
`define STF_BIT_THERM_PREWARN 0

// reset contents
`define STF_RST_SUPA 8'h00
`define STF_RST_SUPB_POR 8'h80
`define STF_RST_SUPB_SOFT 8'h00
`define STF_RST_THRM 8'h00
`define STF_BYTE_ZERO 8'h00

// main-rail short timing: 2 ms at 25 MHz
`define STF_SHORT_TIME_US 2000
`define STF_CLK_MHZ 25
`define STF_SHORT_CYCLES (`STF_SHORT_TIME_US * `STF_CLK_MHZ)
`define STF_SHORT_CNT_W 16

// severe shutdown safe-state count: more than 16 in a row
`define STF_SEVERE_LIMIT 5'h10
`define STF_SEVERE_CNT_W 5
// waiting times in seconds
`define STF_WAIT_NORMAL_S 1
`define STF_WAIT_SAFE_S 60

`endif

// *** inc/stf_pkg.sv ***
package stf_pkg;

    typedef enum logic [2:0] {
        STF_MODE_INIT    = 3'b000,
        STF_MODE_NORMAL  = 3'b001,
        STF_MODE_STOP    = 3'b010,
        STF_MODE_SLEEP   = 3'b011,
        STF_MODE_RESTART = 3'b100,
        STF_MODE_FAIL    = 3'b101
    } stf_mode_t;

    typedef struct packed {
        logic batteryLow;
        logic batteryHigh;
        logic mainOver;
        logic mainPrewarn;
        logic mainUnder;
        logic auxOvertemp;
        logic auxUnder;
        logic severeTsd;
        logic moduleTsd;
        logic thermPrewarn;
    } stf_events_t;

    typedef struct packed {
        stf_mode_t mode;
        logic mainRailOn;
        logic resetOutputReleased;
        logic loadAbovePeak;
        logic pumpEnableBit;
    } stf_qual_t;

    typedef struct packed {
        logic valid;
        logic [15:0] frame;
    } stf_cmd_t;

endpackage

// *** src/stf_short_timer.sv ***
`timescale 1ns/1ns
`include "stf_defs.svh"

module stf_short_timer
    import stf_pkg::*;
#(
    parameter int SHORT_CYCLES = `STF_SHORT_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic mainRailOn,
    input wire logic mainUnder,
    output logic shortDetect
);
    logic [`STF_SHORT_CNT_W-1:0] cnt_r;
    logic [`STF_SHORT_CNT_W-1:0] cnt_nxt;
    logic shortDetect_r;
    logic shortDetect_nxt;

    // counts only while the rail is on and held below its reset threshold
    always_comb begin
        cnt_nxt = cnt_r;
        shortDetect_nxt = 1'b0;
        if (!mainRailOn || !mainUnder) begin
            cnt_nxt = '0;
        end else if (cnt_r > SHORT_CYCLES[`STF_SHORT_CNT_W-1:0]) begin
            shortDetect_nxt = 1'b1;
        end else begin
            cnt_nxt = cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= '0;
            shortDetect_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            shortDetect_r <= shortDetect_nxt;
        end
    end

    assign shortDetect = shortDetect_r;

endmodule // stf_short_timer

// *** src/stf_severe_counter.sv ***
`timescale 1ns/1ns
`include "stf_defs.svh"

module stf_severe_counter
    import stf_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic severeEvent,
    input wire logic severeQuiet,
    output logic safeState,
    output logic longWait
);
    logic [`STF_SEVERE_CNT_W-1:0] cnt_r;
    logic [`STF_SEVERE_CNT_W-1:0] cnt_nxt;
    logic longWait_r;
    logic longWait_nxt;

    // saturating count of back-to-back severe shutdowns
    always_comb begin
        cnt_nxt = cnt_r;
        longWait_nxt = longWait_r;
        // a quiet spell restarts the run only; the long wait stays until reset
        if (severeQuiet) begin
            cnt_nxt = '0;
        end else if (severeEvent) begin
            if (cnt_r == `STF_SEVERE_LIMIT) begin
                longWait_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= '0;
            longWait_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            longWait_r <= longWait_nxt;
        end
    end

    // high on the seventeenth event in a row and on every later event of that run
    assign safeState = severeEvent && !severeQuiet && (cnt_r == `STF_SEVERE_LIMIT);
    assign longWait = longWait_r;

endmodule // stf_severe_counter

// *** dv/stf_host_model.sv ***
`timescale 1ns/1ns

module stf_host_model
    import stf_pkg::*;
(
    input wire logic clk,
    output stf_cmd_t cmdOut
);
    logic [7:0] fill_r = 8'h5a;

    initial cmdOut = '0;

    // --------------------------------------------------------------
    // one command frame per call, held for exactly one taking edge
    // --------------------------------------------------------------
    task automatic send(input logic [6:0] addr, input logic clr);
        @(posedge clk);
        cmdOut <= '{1'b1, {fill_r, clr, addr}};
        @(posedge clk);
        cmdOut.valid <= 1'b0;
        // released frame shows the inverse so a stale word never looks live
        cmdOut.frame <= ~{fill_r, clr, addr};
        fill_r <= fill_r + 8'h1d;
    endtask
endmodule // stf_host_model

// *** dv/tb_supply_thermal_status_flags.sv ***
`timescale 1ns/1ns

module tb_supply_thermal_status_flags
    import stf_pkg::*;
;
    localparam int SHORT_CYC = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic porIn = 1'b0;
    logic softIn = 1'b0;
    stf_events_t ev = '0;
    stf_qual_t qual = '{STF_MODE_NORMAL, 1'b1, 1'b1, 1'b0, 1'b0};
    stf_cmd_t cmd;
    logic [7:0] readData;
    logic readValid, failSafe, modDis, longWait, hit;
    logic [7:0] expQ[$];
    int failures = 0;
    int num_checks = 0;
    logic [31:0] seed = 32'h07c1_ae85;

    initial begin
        forever #20 clk = ~clk;
    end

    stf_status_regs #(.SHORT_CYCLES(SHORT_CYC)) uut (
        .clk(clk), .rst(rst), .powerOnReset(porIn), .softReset(softIn),
        .eventsIn(ev), .qualIn(qual), .cmdIn(cmd), .readData(readData),
        .readValid(readValid), .addrHit(hit), .failSafeRequest(failSafe),
        .moduleDisable(modDis), .severeLongWait(longWait)
    );

    stf_host_model host (.clk(clk), .cmdOut(cmd));

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic isMapped(input logic [6:0] a);
        return (a == 7'h40) || (a == 7'h41) || (a == 7'h42);
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic rd(input logic [6:0] addr, input logic clr, input logic [7:0] exp);
        expQ.push_back(exp);
        host.send(addr, clr);
    endtask

    // events are levels; allow sync plus register before reading
    task automatic pulse(input stf_events_t e, input int n);
        @(posedge clk);
        ev <= e;
        repeat (n) @(posedge clk);
        ev <= '0;
        repeat (5) @(posedge clk);
    endtask

    task automatic stop_test();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // --------------------------------------------------------------
    // read-back monitor
    // --------------------------------------------------------------
    always @(posedge clk) begin
        if (cmd.valid === 1'b1) begin
            check({7'h00, hit}, {7'h00, isMapped(cmd.frame[6:0])});
        end
        if (readValid === 1'b1) begin
            if (expQ.size() == 0) begin
                failures++;
            end else begin
                check(readData, expQ.pop_front());
            end
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        stop_test();
    end

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(7'h40, 1'b0, 8'h00);
        rd(7'h41, 1'b1, 8'h80);
        rd(7'h42, 1'b0, 8'h00);
        rd(7'h41, 1'b0, 8'h00);
        $display("test reset values done");

        pulse(10'h3ff, 4);
        rd(7'h40, 1'b1, 8'h63);
        rd(7'h41, 1'b1, 8'h19);
        rd(7'h42, 1'b1, 8'h07);
        rd(7'h40, 1'b0, 8'h00);
        rd(7'h42, 1'b0, 8'h00);
        $display("test all flags done");

        qual.mode <= STF_MODE_STOP;
        pulse(10'h300, 4);
        rd(7'h40, 1'b1, 8'h00);
        qual.loadAbovePeak <= 1'b1;
        pulse(10'h300, 4);
        rd(7'h40, 1'b1, 8'h60);
        qual.loadAbovePeak <= 1'b0;
        qual.pumpEnableBit <= 1'b1;
        pulse(10'h300, 4);
        rd(7'h40, 1'b1, 8'h20);
        $display("test stop gating done");

        qual <= '{STF_MODE_SLEEP, 1'b0, 1'b1, 1'b0, 1'b0};
        pulse(10'h3a0, 4);
        rd(7'h40, 1'b1, 8'h00);
        rd(7'h41, 1'b1, 8'h00);
        qual <= '{STF_MODE_RESTART, 1'b1, 1'b1, 1'b0, 1'b0};
        pulse(10'h020, 4);
        rd(7'h41, 1'b1, 8'h00);
        qual <= '{STF_MODE_INIT, 1'b1, 1'b0, 1'b0, 1'b0};
        pulse(10'h020, 4);
        rd(7'h41, 1'b1, 8'h00);
        qual.resetOutputReleased <= 1'b1;
        pulse(10'h020, 4);
        rd(7'h41, 1'b1, 8'h01);
        $display("test mode gating done");

        qual.mode <= STF_MODE_NORMAL;
        pulse(10'h020, SHORT_CYC - 3);
        rd(7'h41, 1'b1, 8'h01);
        pulse(10'h020, SHORT_CYC + 10);
        rd(7'h41, 1'b1, 8'h05);
        $display("test short detect done");

        @(posedge clk);
        ev <= 10'h006;
        repeat (20) @(posedge clk);
        @(negedge clk);
        check({6'h00, failSafe, modDis}, 8'h03);
        @(posedge clk);
        ev <= '0;
        repeat (5) @(posedge clk);
        @(negedge clk);
        check({7'h00, longWait}, 8'h01);
        rd(7'h42, 1'b1, 8'h0e);
        $display("test severe shutdown done");

        pulse(10'h3ff, 2);
        softIn <= 1'b1;
        @(posedge clk);
        softIn <= 1'b0;
        rd(7'h40, 1'b0, 8'h00);
        rd(7'h41, 1'b0, 8'h00);
        rd(7'h42, 1'b0, 8'h00);
        @(posedge clk);
        porIn <= 1'b1;
        @(posedge clk);
        porIn <= 1'b0;
        rd(7'h41, 1'b0, 8'h80);
        $display("test soft and power-on reset done");

        for (int i = 0; i < 8; i++) begin
            seed = xorshift(seed);
            rd(7'h43 + 7'(seed % 61), 1'b1, 8'h00);
        end
        $display("test unmapped reads done");

        // one-cycle prewarn lands in the very cycle the clear is taken
        @(posedge clk);
        ev <= 10'h001;
        @(posedge clk);
        ev <= '0;
        rd(7'h42, 1'b1, 8'h00);
        rd(7'h42, 1'b0, 8'h01);
        $display("test event beats clear done");

        for (int i = 0; i < 10 && expQ.size() > 0; i++) begin
            @(posedge clk);
        end
        if (expQ.size() > 0) begin
            failures++;
        end
        stop_test();
    end
endmodule // tb_supply_thermal_status_flags
